// [logic/ssp_strap_pad_cfg.v]
// Purpose: strap capture, debug/host pad routing and pad defaults
// Assumes: pins are asynchronous and synchronised before use
// Notes: pull outputs are {enable, up}; settle count is a parameter
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_strap_pad_cfg #(
    parameter SETTLE_CYC = `SSP_SETTLE_CYC
) (
    clock,
    reset,
    wlan_regulator_enable,
    sleep_req,
    strap_host_sel_pin,
    strap_dbg_sel_pin,
    gpio_in,
    sdio_pad_in,
    sdio_core_out,
    sdio_core_oe,
    jtag_tdo,
    swd_out,
    swd_oe,
    clk_req_level,
    clk_req_push_pull,
    reg_pd_disable,
    gpio_pull_we,
    gpio_pull_val,
    strap_done,
    host_is_sdio,
    dbg_mode,
    pwr_state,
    sdio_pad_out,
    sdio_pad_oe,
    sdio_pad_pull,
    jtag_in,
    swd_in,
    swd_pad_out,
    swd_pad_oe,
    out_of_band_irq,
    shared_io_router_in,
    clk_req_out,
    clk_req_oe,
    clk_req_pull_down,
    clk_req_keeper_en,
    reg_en_pull_down,
    dbg_sel_pull_down,
    gpio_pull,
    gpio_keeper_en
);
    input wire clock;
    input wire reset;
    input wire wlan_regulator_enable;
    input wire sleep_req;
    input wire strap_host_sel_pin;
    input wire strap_dbg_sel_pin;
    input wire [4:0] gpio_in;
    input wire [5:0] sdio_pad_in;
    input wire [5:0] sdio_core_out;
    input wire [5:0] sdio_core_oe;
    input wire jtag_tdo;
    input wire swd_out;
    input wire swd_oe;
    input wire clk_req_level;
    input wire clk_req_push_pull;
    input wire reg_pd_disable;
    input wire [4:0] gpio_pull_we;
    input wire [1:0] gpio_pull_val;
    output reg strap_done;
    output reg host_is_sdio;
    output reg [1:0] dbg_mode;
    output reg [1:0] pwr_state;
    output reg [5:0] sdio_pad_out;
    output reg [5:0] sdio_pad_oe;
    output reg [1:0] sdio_pad_pull;
    output reg [3:0] jtag_in;
    output reg swd_in;
    output reg swd_pad_out;
    output reg swd_pad_oe;
    output reg out_of_band_irq;
    output reg [7:0] shared_io_router_in;
    output reg clk_req_out;
    output reg clk_req_oe;
    output reg clk_req_pull_down;
    output reg clk_req_keeper_en;
    output reg reg_en_pull_down;
    output reg dbg_sel_pull_down;
    output wire [9:0] gpio_pull;
    output wire [4:0] gpio_keeper_en;

    // ==========================================
    // Input synchronisers
    // They reset low, so the pads read as unpowered for two cycles
    // after reset until the regulator enable has passed both stages
    wire reg_en_s;
    wire sleep_s;
    wire host_sel_s;
    wire dbg_sel_s;
    wire [4:0] gpio_s;
    ssp_sync2 #(.WIDTH(9)) u_sync (
        .clock(clock),
        .reset(reset),
        .d({wlan_regulator_enable, sleep_req, strap_host_sel_pin, strap_dbg_sel_pin, gpio_in}),
        .q({reg_en_s, sleep_s, host_sel_s, dbg_sel_s, gpio_s})
    );

    // Debug clock passes the synchronisers too, so it must run well below the system clock
    wire [5:0] sdio_in_s;
    ssp_sync2 #(.WIDTH(6)) u_sdio_sync (
        .clock(clock),
        .reset(reset),
        .d(sdio_pad_in),
        .q(sdio_in_s)
    );

    // ==========================================
    // Strap capture
    reg [`SSP_CNT_W-1:0] settle_q;
    reg done_q;
    reg host_q;
    reg [1:0] dbg_q;
    // Counter is wide enough for the default count of 400000 cycles
    // Capture restarts whenever the regulator enable drops
    localparam integer SETTLE_LAST_I = SETTLE_CYC - 1;
    wire [`SSP_CNT_W-1:0] settle_last = SETTLE_LAST_I[`SSP_CNT_W-1:0];
    reg [1:0] dbg_d;
    always @* begin
        case ({dbg_sel_s, gpio_s[2], gpio_s[1]})
            3'h0: dbg_d = `SSP_DBG_NORMAL;
            3'h1: dbg_d = `SSP_DBG_JTAG;
            3'h3: dbg_d = `SSP_DBG_SWD;
            default: dbg_d = `SSP_DBG_NORMAL;
        endcase
    end
    always @(posedge clock) begin
        if (reset || !reg_en_s) begin
            settle_q <= {`SSP_CNT_W{1'b0}};
            done_q <= 1'b0;
            host_q <= `SSP_HOST_SEL_RST;
            dbg_q <= `SSP_DBG_NORMAL;
        end else if (!done_q) begin
            if (settle_q == settle_last) begin
                done_q <= 1'b1;
                host_q <= host_sel_s;
                dbg_q <= dbg_d;
            end else begin
                settle_q <= settle_q + 1'b1;
            end
        end
    end

    // ==========================================
    // Power state
    reg [1:0] pwr_d;
    always @* begin
        if (!reg_en_s) begin
            pwr_d = `SSP_PWR_DOWN;
        end else if (!done_q) begin
            pwr_d = `SSP_PWR_OOR;
        end else if (sleep_s) begin
            pwr_d = `SSP_PWR_SLEEP;
        end else begin
            pwr_d = `SSP_PWR_ACTIVE;
        end
    end

    // ==========================================
    // General pin defaults
    // strap pins pulled to default, except pin 2
    // pin 0 unpulled; pins 3,4 up, pin 2 none
    wire [9:0] hw_pull = {`SSP_PULL_UP, `SSP_PULL_UP, `SSP_PULL_NONE, `SSP_PULL_DOWN, `SSP_PULL_NONE};
    genvar g;
    generate
        for (g = 0; g < `SSP_GPIO_COUNT; g = g + 1) begin : g_pad
            ssp_gpio_pad u_pad (
                .clock(clock),
                .reset(reset),
                .pwr_state(pwr_state),
                .hw_pull(hw_pull[2*g+1:2*g]),
                .sw_pull_we(gpio_pull_we[g] & done_q),
                .sw_pull(gpio_pull_val),
                .pull(gpio_pull[2*g+1:2*g]),
                .keeper_en(gpio_keeper_en[g])
            );
        end
    endgenerate

    // ==========================================
    // Mode and status outputs
    // Decoded from the next state so pads and state move on one edge
    wire down = (pwr_d == `SSP_PWR_DOWN);
    wire jtag_on = done_q && (dbg_q == `SSP_DBG_JTAG);
    wire swd_on = done_q && (dbg_q == `SSP_DBG_SWD);
    always @(posedge clock) begin
        if (reset) begin
            strap_done <= 1'b0;
            host_is_sdio <= `SSP_HOST_SEL_RST;
            dbg_mode <= `SSP_DBG_NORMAL;
            pwr_state <= `SSP_PWR_OOR;
        end else begin
            strap_done <= done_q;
            host_is_sdio <= host_q;
            dbg_mode <= dbg_q;
            pwr_state <= pwr_d;
        end
    end

    // ==========================================
    // SDIO and debug pad routing, registered outputs
    always @(posedge clock) begin
        if (reset) begin
            sdio_pad_out <= 6'h00;
            sdio_pad_oe <= 6'h00;
            sdio_pad_pull <= `SSP_PULL_UP;
            jtag_in <= 4'h0;
            swd_in <= 1'b0;
            swd_pad_out <= 1'b0;
            swd_pad_oe <= 1'b0;
            out_of_band_irq <= 1'b0;
            shared_io_router_in <= 8'h00;
        end else begin
            if (down) begin
                sdio_pad_out <= 6'h00;
                sdio_pad_oe <= 6'h00;
                sdio_pad_pull <= `SSP_PULL_NONE;
            end else if (jtag_on) begin
                // JTAG on SDIO pads, TDO on data 0
                sdio_pad_out <= {5'h00, jtag_tdo};
                sdio_pad_oe <= 6'h01;
                sdio_pad_pull <= `SSP_PULL_NONE;
            end else begin
                sdio_pad_out <= sdio_core_out;
                sdio_pad_oe <= sdio_core_oe;
                sdio_pad_pull <= done_q ? `SSP_PULL_NONE : `SSP_PULL_UP;
            end
            // JTAG inputs from SDIO data 1 to 3 and clock
            jtag_in <= jtag_on ? {sdio_in_s[5], sdio_in_s[3:1]} : 4'h0;
            // SWD data both ways on debug pin 2
            swd_in <= swd_on ? gpio_s[2] : 1'b0;
            swd_pad_out <= swd_on & swd_out;
            swd_pad_oe <= swd_on & swd_oe;
            // pin 0 returns to its function after capture; router lines follow pins 3 and 4 at all times, pin 2 outside SWD
            out_of_band_irq <= done_q ? gpio_s[0] : 1'b0;
            // router lines 0, 1 and 7; SWD takes pin 2 off line 7
            shared_io_router_in <= {gpio_s[2] & ~swd_on, 5'h00, gpio_s[4], gpio_s[3]};
        end
    end

    // ==========================================
    // Clock request and strap pulls
    always @(posedge clock) begin
        if (reset) begin
            clk_req_out <= 1'b0;
            clk_req_oe <= 1'b0;
            clk_req_pull_down <= 1'b0;
            clk_req_keeper_en <= 1'b1;
            reg_en_pull_down <= 1'b1;
            dbg_sel_pull_down <= 1'b1;
        end else begin
            // open drain out of reset, programmable later
            if (down) begin
                clk_req_out <= 1'b0;
                clk_req_oe <= 1'b0;
                clk_req_pull_down <= 1'b1;
                clk_req_keeper_en <= 1'b0;
            end else if (done_q && clk_req_push_pull) begin
                clk_req_out <= clk_req_level;
                clk_req_oe <= 1'b1;
                clk_req_pull_down <= 1'b0;
                clk_req_keeper_en <= 1'b1;
            end else begin
                // Open drain: only drive low when not requesting
                clk_req_out <= 1'b0;
                clk_req_oe <= ~clk_req_level;
                clk_req_pull_down <= 1'b0;
                clk_req_keeper_en <= 1'b1;
            end
            // pull-down, disable only active or sleep
            reg_en_pull_down <= ~(reg_pd_disable && done_q && !down);
            dbg_sel_pull_down <= ~down;
        end
    end
endmodule // ssp_strap_pad_cfg

// [logic/ssp_defines.vh]
// Purpose: constants for the strap sampler and pad configuration block
// Assumes: 200 MHz clock
// Notes: timing counts are derived from times in microseconds
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
// Strap settle delay after reset release, in microseconds
`define SSP_SETTLE_US 2000
`define SSP_CLK_MHZ 200
`define SSP_SETTLE_CYC (`SSP_SETTLE_US * `SSP_CLK_MHZ)
`define SSP_CNT_W 20
// Power states
`define SSP_PWR_ACTIVE 2'h0
`define SSP_PWR_SLEEP 2'h1
`define SSP_PWR_DOWN 2'h2
`define SSP_PWR_OOR 2'h3
// Pull encodings: {enable, up}
`define SSP_PULL_NONE 2'h0
`define SSP_PULL_DOWN 2'h2
`define SSP_PULL_UP 2'h3
// Debug modes
`define SSP_DBG_NORMAL 2'h0
`define SSP_DBG_JTAG 2'h1
`define SSP_DBG_SWD 2'h2
// Host select reset value and general pin count
`define SSP_HOST_SEL_RST 1'h1
`define SSP_GPIO_COUNT 5
`endif

// [logic/ssp_sync2.v]
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: single clock, synchronous reset
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module ssp_sync2 #(
    parameter WIDTH = 1
) (
    clock,
    reset,
    d,
    q
);
    input wire clock;
    input wire reset;
    input wire [WIDTH-1:0] d;
    output reg [WIDTH-1:0] q;
    reg [WIDTH-1:0] meta_q;
    always @(posedge clock) begin
        if (reset) begin
            meta_q <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // ssp_sync2

// [logic/ssp_gpio_pad.v]
// Purpose: per-pin pull and keeper control for one general pin
// Assumes: pull programming is written by software after strap capture
// Notes: software pull overrides hardware default once written, in active and sleep only
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_gpio_pad (
    clock,
    reset,
    pwr_state,
    hw_pull,
    sw_pull_we,
    sw_pull,
    pull,
    keeper_en
);
    input wire clock;
    input wire reset;
    input wire [1:0] pwr_state;
    input wire [1:0] hw_pull;
    input wire sw_pull_we;
    input wire [1:0] sw_pull;
    output reg [1:0] pull;
    output reg keeper_en;
    reg sw_owned_q;
    reg [1:0] sw_pull_q;
    always @(posedge clock) begin
        if (reset) begin
            sw_owned_q <= 1'b0;
            sw_pull_q <= `SSP_PULL_NONE;
        end else if (sw_pull_we) begin
            sw_owned_q <= 1'b1;
            sw_pull_q <= sw_pull;
        end
    end
    always @* begin
        pull = sw_owned_q ? sw_pull_q : hw_pull;
        keeper_en = 1'b1;
        if (pwr_state == `SSP_PWR_DOWN) begin
            pull = `SSP_PULL_NONE;
            keeper_en = 1'b0;
        end else if (pwr_state == `SSP_PWR_OOR) begin
            pull = hw_pull;
        end
    end
endmodule // ssp_gpio_pad

// [dv/ssp_props_properties.sv]
// Purpose: port assertions for the strap sampler and pad block
// Assumes: one clock, synchronous active-high reset
// Notes: pin paths get six cycles to pass the synchronisers
`timescale 1ns/1ps
module ssp_props (
    input wire clock,
    input wire reset,
    input wire wlan_regulator_enable,
    input wire sleep_req,
    input wire strap_done,
    input wire host_is_sdio,
    input wire [1:0] dbg_mode,
    input wire [1:0] pwr_state,
    input wire [5:0] sdio_pad_oe,
    input wire [1:0] sdio_pad_pull,
    input wire clk_req_out,
    input wire clk_req_oe,
    input wire clk_req_pull_down,
    input wire clk_req_keeper_en,
    input wire reg_en_pull_down,
    input wire [9:0] gpio_pull,
    input wire [4:0] gpio_keeper_en
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // ========================================
    // Checks
    rst_state_a: assert property (disable iff (1'b0) reset |=> !strap_done && host_is_sdio && pwr_state == 2'h3)
        else $error("reset state wrong");
    hold_mode_a: assert property (strap_done && $past(strap_done) && $past(strap_done, 2)
        |-> $stable(dbg_mode) && $stable(host_is_sdio))
        else $error("captured mode moved");
    down_state_a: assert property (!wlan_regulator_enable [*6] |-> pwr_state == 2'h2)
        else $error("no power-down");
    down_pads_a: assert property (pwr_state == 2'h2 && $past(pwr_state) == 2'h2
        |-> gpio_pull == 10'h000 && sdio_pad_oe == 6'h00 && sdio_pad_pull == 2'h0)
        else $error("pads live in power-down");
    pad_keeper_a: assert property ($stable(pwr_state)
        |-> gpio_keeper_en == {5{pwr_state != 2'h2}} && clk_req_keeper_en == (pwr_state != 2'h2))
        else $error("keeper wrong");
    oor_pull_a: assert property (pwr_state == 2'h3 && $past(pwr_state) == 2'h3
        |-> gpio_pull == 10'h3C8 && sdio_pad_pull == 2'h3 && !(clk_req_oe && clk_req_out))
        else $error("out-of-reset pads wrong");
    clk_down_a: assert property (pwr_state == 2'h2 && $past(pwr_state) == 2'h2 |-> clk_req_pull_down)
        else $error("clock request not pulled down");
    reg_pd_a: assert property (pwr_state[1] && $past(pwr_state[1]) |-> reg_en_pull_down)
        else $error("regulator pull-down off");
    sleep_state_a: assert property ((strap_done && wlan_regulator_enable && sleep_req) [*6]
        |-> pwr_state == 2'h1)
        else $error("no sleep state");
    cover property ($rose(strap_done));
    cover property (strap_done && dbg_mode == 2'h1);
    cover property (strap_done && dbg_mode == 2'h2);
endmodule // ssp_props
bind ssp_strap_pad_cfg ssp_props ssp_props_inst (.*);

// [dv/ssp_board.sv]
// Purpose: board straps, host and debugger at the pads
// Assumes: a pin is driven, else pulled, else floating
// Notes: a float toggles so it never passes for a steady level
`timescale 1ns/1ps
module ssp_board (
    input wire clock,
    input wire [6:0] drv_en,
    input wire [6:0] drv_val,
    input wire [1:0] sdio_pad_pull,
    input wire dbg_sel_pull_down,
    input wire [9:0] gpio_pull,
    output logic [6:0] pin
);
    logic flt_q = 1'b0;
    always @(posedge clock) flt_q <= !flt_q;
    always_comb begin
        for (int i = 0; i < 5; i++)
            pin[i] = drv_en[i] ? drv_val[i] : gpio_pull[2*i+1] ? gpio_pull[2*i] : flt_q;
        pin[5] = drv_en[5] ? drv_val[5] : sdio_pad_pull[1] ? sdio_pad_pull[0] : flt_q;
        pin[6] = drv_en[6] ? drv_val[6] : dbg_sel_pull_down ? 1'b0 : flt_q;
    end
endmodule // ssp_board

// [dv/tb_ssp_strap_pad_cfg.sv]
// Purpose: self-checking bench for the strap sampler and pad block
// Assumes: inputs change on the falling edge
// Notes: settle count cut to 16 cycles to keep the run short
`timescale 1ns/1ps
module tb_ssp_strap_pad_cfg;
    logic clock = 1'b0, reset = 1'b1, wlan_regulator_enable = 1'b1, sleep_req = 1'b0, jtag_tdo = 1'b0;
    logic swd_out = 1'b0, swd_oe = 1'b0, clk_req_level = 1'b0, clk_req_push_pull = 1'b0, reg_pd_disable = 1'b0;
    logic [5:0] sdio_core_out = 6'h00, sdio_core_oe = 6'h00;
    // host drives every SDIO pad input, clock included
    logic [5:0] sdio_pad_in = 6'h00;
    logic [4:0] gpio_pull_we = 5'h00;
    logic [1:0] gpio_pull_val = 2'h0;
    logic [6:0] drv_en = 7'h00, drv_val = 7'h00;
    wire [6:0] pin;
    wire strap_done, host_is_sdio, swd_in, out_of_band_irq, clk_req_out, clk_req_oe, clk_req_pull_down;
    wire clk_req_keeper_en, reg_en_pull_down, dbg_sel_pull_down;
    wire swd_pad_out, swd_pad_oe;
    wire [1:0] dbg_mode, pwr_state, sdio_pad_pull;
    wire [5:0] sdio_pad_out, sdio_pad_oe;
    wire [3:0] jtag_in;
    wire [7:0] shared_io_router_in;
    wire [9:0] gpio_pull;
    wire [4:0] gpio_keeper_en;
    int bad_count = 0, n_compared = 0;
    ssp_strap_pad_cfg #(.SETTLE_CYC(16)) ssp_strap_pad_cfg_inst (.gpio_in(pin[4:0]), .strap_host_sel_pin(pin[5]),
        .strap_dbg_sel_pin(pin[6]), .*);
    ssp_board ssp_board_inst (.*);
    always #2.5 clock = ~clock;
    // ========================================
    // Helpers
    task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task wait_done;
        for (int i = 0; i < 60 && strap_done !== 1'b1; i++) cyc(1);
        chk("strap_done", strap_done, 1'b1);
        cyc(2);
    endtask
    task boot(input logic [6:0] en, input logic [6:0] val);
        drv_en = en;
        drv_val = val;
        reset = 1'b1;
        cyc(12);
        chk("oor gpio_pull", gpio_pull, 10'h3C8);
        chk("oor sdio pull", sdio_pad_pull, 2'h3);
        chk("oor jtag sel pd", dbg_sel_pull_down, 1'b1);
        reset = 1'b0;
        wait_done;
    endtask
    // ========================================
    // Scenarios
    task t_modes;
        logic [2:0] code [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h7};
        logic [1:0] mode [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
        for (int k = 0; k < 5; k++) begin
            boot(code[k][2] ? 7'h66 : 7'h46, {code[k][2], 3'h0, code[k][1:0], 1'b0});
            chk("dbg_mode", dbg_mode, mode[k]);
            chk("host_is_sdio", host_is_sdio, !code[k][2]);
            sdio_core_out = 6'h2A;
            sdio_core_oe = 6'h3F;
            sdio_pad_in = 6'h2A;
            jtag_tdo = 1'b1;
            swd_out = 1'b1;
            swd_oe = 1'b1;
            drv_en = 7'h1F;
            drv_val = 7'h17;
            cyc(6);
            chk("mode held", dbg_mode, mode[k]);
            chk("oob irq", out_of_band_irq, 1'b1);
            chk("router", {shared_io_router_in[7], shared_io_router_in[1:0]}, mode[k] == 2'h2 ? 3'h2 : 3'h6);
            chk("jtag_in", jtag_in, mode[k] == 2'h1 ? 4'hD : 4'h0);
            chk("swd_in", swd_in, mode[k] == 2'h2);
            chk("swd pad", {swd_pad_oe, swd_pad_out}, mode[k] == 2'h2 ? 2'h3 : 2'h0);
            chk("sdio pads", {sdio_pad_oe, sdio_pad_out}, mode[k] == 2'h1 ? 12'h041 : 12'hFEA);
        end
    endtask
    task t_soft;
        boot(7'h04, 7'h00);
        for (int i = 0; i < 5; i++) begin
            gpio_pull_we = 5'h01 << i;
            gpio_pull_val = i[0] ? 2'h2 : 2'h3;
            cyc(1);
        end
        gpio_pull_we = 5'h00;
        reg_pd_disable = 1'b1;
        clk_req_level = 1'b1;
        clk_req_push_pull = 1'b1;
        cyc(4);
        chk("sw pulls", gpio_pull, 10'h3BB);
        chk("reg pd off", reg_en_pull_down, 1'b0);
        chk("push-pull", {clk_req_out, clk_req_oe}, 2'h3);
        clk_req_push_pull = 1'b0;
        cyc(4);
        // Open drain never drives the line high
        chk("open drain", clk_req_oe, 1'b0);
    endtask
    task t_power;
        sleep_req = 1'b1;
        cyc(6);
        chk("sleep", pwr_state, 2'h1);
        chk("sleep keeper", clk_req_keeper_en, 1'b1);
        wlan_regulator_enable = 1'b0;
        cyc(6);
        chk("down", {pwr_state, strap_done, gpio_keeper_en}, 8'h80);
        chk("down pd", reg_en_pull_down, 1'b1);
        wlan_regulator_enable = 1'b1;
        sleep_req = 1'b0;
        wait_done;
        chk("active", pwr_state, 2'h0);
    endtask
    initial begin
        t_modes;
        t_soft;
        t_power;
        results;
    end
    // Watchdog well past the roughly 275 cycles the scenarios take
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        results;
    end
endmodule // tb_ssp_strap_pad_cfg
